// ==== psm_cfg.svh ====
// constants for the per-second performance and sequence monitor
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PSM_CTRL 8'h00
`define PSM_STATUS 8'h04
`define PSM_MASK 8'h08
`define PSM_STATE 8'h0C
`define PSM_TOTAL 8'h10
`define PSM_UAT 8'h14
`define PSM_AVT 8'h18
`define PSM_ES 8'h1C
`define PSM_SES 8'h20
`define PSM_ALS 8'h24
`define PSM_EFS 8'h28
`define PSM_SEQERR 8'h2C
`define PSM_SEQLOSS 8'h30
`define PSM_TXSEQ 8'h34

// ----------------------------------------
// field positions
// ----------------------------------------
`define PSM_CTRL_START 0
`define PSM_CTRL_STOP 1
`define PSM_EV_TICK 0
`define PSM_EV_UA_IN 1
`define PSM_EV_UA_OUT 2
`define PSM_EV_SEQERR 3
`define PSM_EV_SEQLOSS 4
`define PSM_NEV 5

// ----------------------------------------
// reset values, timing and thresholds
// ----------------------------------------
`define PSM_MASK_RST 5'h00
`define PSM_SEC_NS 1000000000
`define PSM_CLK_NS 10
`define PSM_UA_RUN 4'hA
`define PSM_RATIO_DEN 16'h03E8
`define PSM_SEQ_GROUP 2'h3

`endif

// ==== psm_pkg.sv ====
// types for the per-second performance and sequence monitor
package psm_pkg;
    typedef enum logic {psm_avail, psm_unavail} psm_avail_t;
    typedef logic [31:0] psm_word_t;
endpackage

// ==== psm_sync.sv ====
// three-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module psm_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire [W-1:0] agree = ~(s2 ^ s3);
    wire [W-1:0] next_sync_out = (agree & s3) | (~agree & sync_out);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sync_out <= '0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            sync_out <= next_sync_out;
        end
    end
endmodule

// ==== psm_seq.sv ====
// receive sequence-number checker and transmit numbering
`timescale 1ns/1ps
`include "psm_cfg.svh"
module psm_seq (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    // transmit numbering
    input wire logic tx_seq_req,
    output logic [15:0] tx_seq_num,
    // received frames
    input wire logic rx_seq_valid,
    input wire logic [15:0] rx_seq_num,
    // group results, one-cycle pulses
    output logic seq_error,
    output logic seq_sync_loss
);
    logic [15:0] expect_num;
    logic [15:0] held_num;
    logic held;
    logic locked;
    logic [1:0] grp_cnt;
    logic grp_err;
    logic grp_loss;

    // per-frame classification
    wire match = locked && rx_seq_num == expect_num;
    wire skip_one = locked && !held && rx_seq_num == expect_num + 16'h0001;
    wire swap_back = held && rx_seq_num == held_num;
    wire frame_err = rx_seq_valid && swap_back;
    wire frame_loss = rx_seq_valid && locked && (held ? !swap_back : (!match && !skip_one));
    wire grp_end = rx_seq_valid && grp_cnt == `PSM_SEQ_GROUP;
    wire [15:0] next_expect = swap_back ? expect_num : rx_seq_num + 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_seq_num <= 16'h0000;
        end else if (restart) begin
            tx_seq_num <= 16'h0000;
        end else if (tx_seq_req) begin
            tx_seq_num <= tx_seq_num + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expect_num <= 16'h0000;
            held_num <= 16'h0000;
            held <= 1'b0;
            locked <= 1'b0;
        end else if (restart) begin
            held <= 1'b0;
            locked <= 1'b0;
        end else if (rx_seq_valid) begin
            expect_num <= next_expect;
            locked <= 1'b1;
            held <= skip_one;
            held_num <= expect_num;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_cnt <= 2'h0;
            grp_err <= 1'b0;
            grp_loss <= 1'b0;
            seq_error <= 1'b0;
            seq_sync_loss <= 1'b0;
        end else begin
            seq_error <= grp_end && (grp_err || frame_err);
            seq_sync_loss <= grp_end && (grp_loss || frame_loss);
            if (restart) begin
                grp_cnt <= 2'h0;
                grp_err <= 1'b0;
                grp_loss <= 1'b0;
            end else if (rx_seq_valid) begin
                grp_cnt <= grp_cnt + 2'h1;
                grp_err <= !grp_end && (grp_err || frame_err);
                grp_loss <= !grp_end && (grp_loss || frame_loss);
            end
        end
    end
endmodule

// ==== psm_top.sv ====
// per-second performance classification and sequence monitor
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "psm_cfg.svh"
module psm_top #(
    parameter int SEC_CYCLES = `PSM_SEC_NS / `PSM_CLK_NS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive defects from the line side
    input wire logic link_down,
    input wire logic remote_fault,
    input wire logic frame_loss_defect,
    input wire logic signal_loss_defect,
    // receive path counts, same clock
    input wire logic [15:0] rx_bits,
    input wire logic [15:0] pattern_errors,
    input wire logic errored_frame,
    input wire logic rx_seq_valid,
    input wire logic [15:0] rx_seq_num,
    // transmit numbering
    input wire logic tx_seq_req,
    output logic [15:0] tx_seq_num,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    psm_pkg::psm_avail_t avail_st;
    logic running;
    logic [31:0] sec_cnt;
    logic [47:0] bit_sum;
    logic [31:0] err_sum;
    logic los_seen;
    logic alarm_seen;
    logic [3:0] run_len;
    logic [3:0] pend_es;
    logic [3:0] pend_ses;
    logic [3:0] pend_als;
    logic [3:0] pend_efs;
    psm_pkg::psm_word_t total;
    psm_pkg::psm_word_t unavailable_time;
    psm_pkg::psm_word_t available_time;
    psm_pkg::psm_word_t es_cnt;
    psm_pkg::psm_word_t ses_cnt;
    psm_pkg::psm_word_t als_cnt;
    psm_pkg::psm_word_t efs_cnt;
    psm_pkg::psm_word_t seqerr_cnt;
    psm_pkg::psm_word_t seqloss_cnt;
    logic [`PSM_NEV-1:0] status;
    logic [`PSM_NEV-1:0] mask;
    logic [3:0] defects;
    logic [15:0] tx_seq_i;
    logic seq_err_p;
    logic seq_loss_p;
    logic ua_in_p;
    logic ua_out_p;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    psm_sync #(.W(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({signal_loss_defect, frame_loss_defect, remote_fault, link_down}),
        .sync_out(defects)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire setup = psel && !penable && !pready;
    wire wr_acc = pready && psel && penable && pwrite;
    wire a_ctrl = paddr == `PSM_CTRL;
    wire a_stat = paddr == `PSM_STATUS;
    wire a_mask = paddr == `PSM_MASK;
    wire mapped = paddr[1:0] == 2'h0 && paddr <= `PSM_TXSEQ;
    wire start_req = wr_acc && a_ctrl && pwdata[`PSM_CTRL_START];
    wire stop_req = wr_acc && a_ctrl && pwdata[`PSM_CTRL_STOP];
    wire [31:0] rd_mux =
        a_ctrl ? {30'h0, running, 1'b0} :
        a_stat ? {27'h0, status} :
        a_mask ? {27'h0, mask} :
        paddr == `PSM_STATE ? {30'h0, running, avail_st == psm_pkg::psm_unavail} :
        paddr == `PSM_TOTAL ? total :
        paddr == `PSM_UAT ? unavailable_time :
        paddr == `PSM_AVT ? available_time :
        paddr == `PSM_ES ? es_cnt :
        paddr == `PSM_SES ? ses_cnt :
        paddr == `PSM_ALS ? als_cnt :
        paddr == `PSM_EFS ? efs_cnt :
        paddr == `PSM_SEQERR ? seqerr_cnt :
        paddr == `PSM_SEQLOSS ? seqloss_cnt :
        paddr == `PSM_TXSEQ ? {16'h0, tx_seq_i} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite && mapped) ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // sequence checker
    // ----------------------------------------
    psm_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .restart(start_req),
        .tx_seq_req(tx_seq_req),
        .tx_seq_num(tx_seq_i),
        .rx_seq_valid(rx_seq_valid && running),
        .rx_seq_num(rx_seq_num),
        .seq_error(seq_err_p),
        .seq_sync_loss(seq_loss_p)
    );

    // ----------------------------------------
    // one-second tick and per-second gathering
    // ----------------------------------------
    wire tick = running && sec_cnt == SEC_CYCLES - 1;
    wire [47:0] err_scaled = {16'h0, err_sum} * {32'h0, `PSM_RATIO_DEN};
    wire ratio_hit = bit_sum != 48'h0 && err_scaled >= bit_sum;
    wire sec_es = err_sum != 32'h0;
    wire sec_ses = ratio_hit || los_seen;
    wire sec_als = alarm_seen;
    wire sec_efs = !sec_es && !sec_ses && !sec_als;
    wire sec_bad = sec_ses || sec_als;
    wire [3:0] next_run = run_len + 4'h1;
    wire run_done = next_run == `PSM_UA_RUN;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running <= 1'b0;
            sec_cnt <= 32'h0;
            bit_sum <= 48'h0;
            err_sum <= 32'h0;
            los_seen <= 1'b0;
            alarm_seen <= 1'b0;
        end else begin
            running <= start_req || (running && !stop_req);
            sec_cnt <= (start_req || tick) ? 32'h0 : sec_cnt + {31'h0, running};
            if (start_req || tick) begin
                bit_sum <= 48'h0;
                err_sum <= 32'h0;
                los_seen <= 1'b0;
                alarm_seen <= 1'b0;
            end else if (running) begin
                bit_sum <= bit_sum + {32'h0, rx_bits};
                err_sum <= err_sum + {16'h0, pattern_errors};
                los_seen <= los_seen || defects[2] || defects[3];
                alarm_seen <= alarm_seen || |defects[2:0] || errored_frame;
            end
        end
    end

    // ----------------------------------------
    // availability tracking and second counters
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avail_st <= psm_pkg::psm_avail;
            run_len <= 4'h0;
            {pend_es, pend_ses, pend_als, pend_efs} <= 16'h0;
            {total, unavailable_time, es_cnt} <= 96'h0;
            {ses_cnt, als_cnt, efs_cnt} <= 96'h0;
            ua_in_p <= 1'b0;
            ua_out_p <= 1'b0;
        end else if (start_req) begin
            avail_st <= psm_pkg::psm_avail;
            run_len <= 4'h0;
            {pend_es, pend_ses, pend_als, pend_efs} <= 16'h0;
            {total, unavailable_time, es_cnt} <= 96'h0;
            {ses_cnt, als_cnt, efs_cnt} <= 96'h0;
            ua_in_p <= 1'b0;
            ua_out_p <= 1'b0;
        end else begin
            ua_in_p <= 1'b0;
            ua_out_p <= 1'b0;
            if (tick) begin
                total <= total + 32'h1;
                unique case (avail_st)
                    psm_pkg::psm_avail: begin
                        if (sec_bad && run_done) begin
                            avail_st <= psm_pkg::psm_unavail;
                            ua_in_p <= 1'b1;
                            unavailable_time <= unavailable_time + 32'hA;
                            es_cnt <= es_cnt - {28'h0, pend_es};
                            ses_cnt <= ses_cnt - {28'h0, pend_ses};
                            als_cnt <= als_cnt - {28'h0, pend_als};
                            efs_cnt <= efs_cnt - {28'h0, pend_efs};
                            run_len <= 4'h0;
                            {pend_es, pend_ses, pend_als, pend_efs} <= 16'h0;
                        end else begin
                            es_cnt <= es_cnt + {31'h0, sec_es};
                            ses_cnt <= ses_cnt + {31'h0, sec_ses};
                            als_cnt <= als_cnt + {31'h0, sec_als};
                            efs_cnt <= efs_cnt + {31'h0, sec_efs};
                            run_len <= sec_bad ? next_run : 4'h0;
                            pend_es <= sec_bad ? pend_es + {3'h0, sec_es} : 4'h0;
                            pend_ses <= sec_bad ? pend_ses + {3'h0, sec_ses} : 4'h0;
                            pend_als <= sec_bad ? pend_als + {3'h0, sec_als} : 4'h0;
                            pend_efs <= 4'h0;
                        end
                    end
                    psm_pkg::psm_unavail: begin
                        if (!sec_ses && run_done) begin
                            avail_st <= psm_pkg::psm_avail;
                            ua_out_p <= 1'b1;
                            unavailable_time <= unavailable_time - 32'h9;
                            es_cnt <= es_cnt + {28'h0, pend_es} + {31'h0, sec_es};
                            als_cnt <= als_cnt + {28'h0, pend_als} + {31'h0, sec_als};
                            efs_cnt <= efs_cnt + {28'h0, pend_efs} + {31'h0, sec_efs};
                            run_len <= 4'h0;
                            {pend_es, pend_ses, pend_als, pend_efs} <= 16'h0;
                        end else begin
                            unavailable_time <= unavailable_time + 32'h1;
                            run_len <= sec_ses ? 4'h0 : next_run;
                            pend_es <= sec_ses ? 4'h0 : pend_es + {3'h0, sec_es};
                            pend_als <= sec_ses ? 4'h0 : pend_als + {3'h0, sec_als};
                            pend_efs <= sec_ses ? 4'h0 : pend_efs + {3'h0, sec_efs};
                            pend_ses <= 4'h0;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // derived results, sequence counters, events
    // ----------------------------------------
    wire [`PSM_NEV-1:0] events = {seq_loss_p, seq_err_p, ua_out_p, ua_in_p, tick};
    wire [`PSM_NEV-1:0] w1c = (wr_acc && a_stat) ? pwdata[`PSM_NEV-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            available_time <= 32'h0;
            seqerr_cnt <= 32'h0;
            seqloss_cnt <= 32'h0;
            status <= '0;
            mask <= `PSM_MASK_RST;
            irq <= 1'b0;
            tx_seq_num <= 16'h0;
        end else begin
            available_time <= total - unavailable_time;
            tx_seq_num <= tx_seq_i;
            seqerr_cnt <= start_req ? 32'h0 : seqerr_cnt + {31'h0, seq_err_p};
            seqloss_cnt <= start_req ? 32'h0 : seqloss_cnt + {31'h0, seq_loss_p};
            status <= (status & ~w1c) | events;
            if (wr_acc && a_mask) begin
                mask <= pwdata[`PSM_NEV-1:0];
            end
            irq <= |(status & mask);
        end
    end
endmodule

// ==== psm_chk.sv ====
// port assertions for the performance and sequence monitor
`timescale 1ns/1ps
`include "psm_cfg.svh"
module psm_chk #(
    parameter int SEC_CYCLES = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // numbering and interrupt
    input wire logic tx_seq_req,
    input wire logic [15:0] tx_seq_num,
    input wire logic irq
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [4:0] mask_r;
    wire bad_addr = (paddr > `PSM_TXSEQ) || (paddr[1:0] != 2'h0);
    wire num_moved;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 5'h00;
        end else if (psel && penable && pready && pwrite && paddr == `PSM_MASK) begin
            mask_r <= pwdata[4:0];
        end
    end
    assign num_moved = (tx_seq_num != 16'h0000);
    a_ready_after_setup: assert property (s_setup |=> s_access)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (psel && !penable && bad_addr |=> pslverr)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (psel && !penable && !bad_addr |=> !pslverr)
        else $error("mapped access refused");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside access");
    a_irq_masked: assert property (irq |-> mask_r != 5'h00 || $past(mask_r) != 5'h00)
        else $error("interrupt with all masked");
    a_txnum_cause: assert property ($changed(tx_seq_num) && num_moved |->
        $past(tx_seq_req) || $past(tx_seq_req, 2) || $past(tx_seq_req, 3))
        else $error("frame number moved without request");
    a_txnum_step: assert property ($changed(tx_seq_num) && num_moved |->
        tx_seq_num == $past(tx_seq_num) + 16'h0001)
        else $error("frame number not one step");
endmodule
bind psm_top psm_chk #(.SEC_CYCLES(SEC_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_seq_req(tx_seq_req),
    .tx_seq_num(tx_seq_num), .irq(irq));

// ==== psm_net_model.sv ====
// behavioural network under test returning numbered frames
`timescale 1ns/1ps
module psm_net_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // command: 0 in order, 1 swap a pair, 2 drop one
    input wire logic [1:0] mode,
    input wire logic go,
    output logic busy,
    // device side
    output logic tx_seq_req,
    input wire logic [15:0] tx_seq_num,
    output logic rx_seq_valid,
    output logic [15:0] rx_seq_num
);
    logic [15:0] num [5];
    int ord [3][4] = '{'{0, 1, 2, 3}, '{0, 2, 1, 3}, '{0, 2, 3, 4}};
    int k;
    initial begin
        busy = 1'b0;
        tx_seq_req = 1'b0;
        rx_seq_valid = 1'b0;
        rx_seq_num = 16'h0000;
        forever begin
            @(posedge pclk);
            if (go === 1'b1 && presetn === 1'b1) begin
                busy <= 1'b1;
                k = (mode == 2'h2) ? 5 : 4;
                for (int i = 0; i < k; i++) begin
                    tx_seq_req <= 1'b1;
                    num[i] = tx_seq_num;
                    @(posedge pclk);
                    tx_seq_req <= 1'b0;
                    repeat (3) @(posedge pclk);
                end
                for (int i = 0; i < 4; i++) begin
                    rx_seq_valid <= 1'b1;
                    rx_seq_num <= num[ord[mode][i]];
                    @(posedge pclk);
                    rx_seq_valid <= 1'b0;
                    // idle bus never shows a stale number
                    rx_seq_num <= ~num[ord[mode][i]];
                    @(posedge pclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the performance and sequence monitor
`timescale 1ns/1ps
`include "psm_cfg.svh"
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0] dfx = 5'h00;
    logic [15:0] perr = 16'h0000;
    logic [1:0] mode = 2'h0;
    logic go = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, busy, tx_req, rx_valid;
    wire [15:0] tx_num, rx_num;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    logic [4:0] dv [8] = '{5'h00, 5'h00, 5'h00, 5'h10, 5'h01, 5'h02, 5'h04, 5'h08};
    logic [15:0] ev [8] = '{16'h0000, 16'h0001, 16'h0100, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000};
    always #5 pclk = ~pclk;
    psm_top #(.SEC_CYCLES(60)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_down(dfx[0]), .remote_fault(dfx[1]),
        .frame_loss_defect(dfx[2]), .signal_loss_defect(dfx[3]), .rx_bits(16'h03E8),
        .pattern_errors(perr), .errored_frame(dfx[4]), .rx_seq_valid(rx_valid),
        .rx_seq_num(rx_num), .tx_seq_req(tx_req), .tx_seq_num(tx_num), .irq(irq));
    psm_net_model i_net (.pclk(pclk), .presetn(presetn), .mode(mode), .go(go), .busy(busy),
        .tx_seq_req(tx_req), .tx_seq_num(tx_num), .rx_seq_valid(rx_valid),
        .rx_seq_num(rx_num));
    // ----------------------------------------
    // access and check tasks
    // ----------------------------------------
    task automatic close_out;
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    // one second with the given defects, then wait for its tick
    task automatic sec(input logic [4:0] d, input logic [15:0] e);
        @(posedge pclk);
        dfx <= d;
        perr <= e;
        @(posedge pclk);
        perr <= 16'h0000;
        dfx[4] <= 1'b0;
        repeat (3) @(posedge pclk);
        dfx <= 5'h00;
        do apb(1'b0, `PSM_STATUS, 32'h00000000); while (rd[0] !== 1'b1);
        apb(1'b1, `PSM_STATUS, 32'h00000001);
    endtask
    task automatic burst(input logic [1:0] m);
        @(posedge pclk);
        mode <= m;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (2) @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(`PSM_MASK, 32'h00000000);
        rdc(8'h38, 32'h00000000);
        chk("slverr", 32'h00000001, {31'h0, er});
        apb(1'b1, `PSM_TOTAL, 32'h00000005);
        rdc(`PSM_TOTAL, 32'h00000000);
        apb(1'b1, `PSM_CTRL, 32'h00000001);
        rdc(`PSM_STATE, 32'h00000002);
        for (int i = 0; i < 8; i++) sec(dv[i], ev[i]);
        rdc(`PSM_ES, 32'h2);
        rdc(`PSM_SES, 32'h3);
        rdc(`PSM_ALS, 32'h4);
        rdc(`PSM_EFS, 32'h1);
        rdc(`PSM_AVT, 32'h8);
        apb(1'b1, `PSM_MASK, 32'h00000002);
        sec(5'h00, 16'h0000);
        repeat (9) sec(5'h04, 16'h0000);
        rdc(`PSM_SES, 32'hC);
        rdc(`PSM_ALS, 32'hD);
        rdc(`PSM_UAT, 32'h0);
        chk("irq low", 32'h0, {31'h0, irq});
        sec(5'h04, 16'h0000);
        rdc(`PSM_UAT, 32'hA);
        rdc(`PSM_SES, 32'h3);
        rdc(`PSM_ALS, 32'h4);
        rdc(`PSM_STATE, 32'h3);
        chk("irq high", 32'h1, {31'h0, irq});
        apb(1'b1, `PSM_STATUS, 32'h00000002);
        repeat (2) @(negedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        repeat (9) sec(5'h00, 16'h0000);
        rdc(`PSM_UAT, 32'h13);
        rdc(`PSM_EFS, 32'h2);
        sec(5'h00, 16'h0000);
        rdc(`PSM_UAT, 32'hA);
        rdc(`PSM_EFS, 32'hC);
        rdc(`PSM_AVT, 32'h13);
        rdc(`PSM_STATE, 32'h2);
        apb(1'b0, `PSM_STATUS, 32'h00000000);
        chk("left flag", 32'h4, rd & 32'h6);
        burst(2'h0);
        burst(2'h1);
        burst(2'h2);
        burst(2'h0);
        rdc(`PSM_SEQERR, 32'h1);
        rdc(`PSM_SEQLOSS, 32'h1);
        rdc(`PSM_TXSEQ, 32'h11);
        apb(1'b0, `PSM_STATUS, 32'h00000000);
        chk("seq flags", 32'h18, rd & 32'h18);
        apb(1'b1, `PSM_CTRL, 32'h00000002);
        rdc(`PSM_CTRL, 32'h0);
        apb(1'b1, `PSM_CTRL, 32'h00000001);
        rdc(`PSM_ES, 32'h0);
        rdc(`PSM_UAT, 32'h0);
        rdc(`PSM_SEQERR, 32'h0);
        close_out();
    end
endmodule
